// ### ee_guard_pkg.sv
// Package: constants for the serial EEPROM write guard and whole-array operations
package ee_guard_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int WORDS = 128;
    // Header after start bit: 2 opcode bits + address bits
    localparam int HDR_W = 2 + ADDR_W;
    localparam int CLK_HZ = 25_000_000;
    // Program cycle time in microseconds
    localparam int PROG_US = 10_000;
    localparam int PROG_CYC = PROG_US * (CLK_HZ / 1_000_000);
    // Host link clock half period in system cycles (divider)
    localparam int LCLK_HALF = 4;
    // Deselect time in ns, rounded up to cycles
    localparam int CSMIN_NS = 1000;
    localparam int CSMIN_CYC = (CSMIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // Opcodes: 2-bit field; 00 extends with the top two address bits
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] EXT_LOCK = 2'h0;
    localparam logic [1:0] EXT_FILL = 2'h1;
    localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
    localparam logic [1:0] EXT_UNLOCK = 2'h3;
    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;
    typedef enum logic [2:0] {
        CMD_LOCK = 3'h1,
        CMD_UNLOCK = 3'h2,
        CMD_ERASE_ALL = 3'h4
    } unused_e;
endpackage : ee_guard_pkg

// ### ee_link_if.sv
// Interface: four-wire serial link between host and EEPROM (select, clock, serial in, serial out)
`timescale 1ns/1ns
interface ee_link_if;
    logic select;
    logic serial_clock_in;
    logic serial_in;
    logic so_data;
    logic so_oe;
    // Resolved output wire level seen by host; pulled high when released
    logic so_line;
    assign so_line = so_oe ? so_data : 1'b1;
    modport device (input select, input serial_clock_in, input serial_in,
                    output so_data, output so_oe);
    modport host (output select, output serial_clock_in, output serial_in,
                  input so_line);
endinterface : ee_link_if

// ### ee_sync2.sv
// Two-flip-flop synchroniser with rise and fall pulses
`timescale 1ns/1ns
module ee_sync2 (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_async,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    logic meta_q;
    logic sync_q;
    logic last_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end
    assign o_level = sync_q;
    assign o_rise = sync_q & ~last_q;
    assign o_fall = ~sync_q & last_q;
endmodule : ee_sync2

// ### ee_device.sv
// Device end: write lock latch, instruction decode, self-timed array cycles
`timescale 1ns/1ns
module ee_device #(
    parameter int PROG_CYCLES = ee_guard_pkg::PROG_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    ee_link_if.device link,
    output logic o_unlocked,
    output logic o_busy
);
    import ee_guard_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_HDR = 5'b00010,
        ST_DATA = 5'b00100,
        ST_READ = 5'b01000,
        ST_DONE = 5'b10000
    } dev_st_e;

    logic sel;
    logic sel_rise;
    logic sel_fall;
    logic lclk_rise;
    logic lclk_fall;
    logic din;
    dev_st_e st_q;
    logic [HDR_W-1:0] hdr_q;
    logic [DATA_W-1:0] dat_q;
    logic [4:0] cnt_q;
    logic [DATA_W-1:0] mem [WORDS];
    logic unlocked_q;
    logic [1:0] pend_q;
    logic [31:0] timer_q;
    logic [6:0] fill_idx_q;
    logic [6:0] job_addr_q;
    logic [DATA_W-1:0] job_word_q;
    logic so_q;
    logic oe_q;
    logic [DATA_W:0] rd_q;

    ee_sync2 u_sel (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_async(link.select),
        .o_level(sel), .o_rise(sel_rise), .o_fall(sel_fall));
    ee_sync2 u_lclk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_async(link.serial_clock_in),
        .o_level(), .o_rise(lclk_rise), .o_fall(lclk_fall));
    ee_sync2 u_sin (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_async(link.serial_in),
        .o_level(din), .o_rise(), .o_fall());

    // Pending array job: 0 none, 1 erase-all, 2 fill, 3 single word write/erase
    logic [1:0] op;
    logic [1:0] ext;
    logic [6:0] waddr;
    assign op = hdr_q[HDR_W-1 -: 2];
    assign ext = hdr_q[ADDR_W-1 -: 2];
    assign waddr = hdr_q[6:0];

    // Serial receive, sampled on rising link clock
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !sel) begin
            st_q <= ST_IDLE;
            cnt_q <= 5'h0;
            hdr_q <= '0;
            dat_q <= '0;
        end else if (lclk_rise) begin
            case (st_q)
                ST_IDLE: begin
                    // Start bit ignored while busy: select only polls status then
                    if (din && !o_busy) begin
                        st_q <= ST_HDR;
                        cnt_q <= 5'h0;
                    end
                end
                ST_HDR: begin
                    hdr_q <= {hdr_q[HDR_W-2:0], din};
                    cnt_q <= cnt_q + 5'h1;
                    if (cnt_q == 5'(HDR_W - 1)) begin
                        cnt_q <= 5'h0;
                        if (hdr_q[HDR_W-2 -: 2] == OP_READ) begin
                            st_q <= ST_READ;
                        end else if (hdr_q[HDR_W-2 -: 2] == OP_WRITE
                                || (hdr_q[HDR_W-2 -: 2] == OP_EXT
                                    && hdr_q[ADDR_W-2 -: 2] == EXT_FILL)) begin
                            st_q <= ST_DATA;
                        end else begin
                            st_q <= ST_DONE;
                        end
                    end
                end
                ST_DATA: begin
                    dat_q <= {dat_q[DATA_W-2:0], din};
                    cnt_q <= cnt_q + 5'h1;
                    if (cnt_q == 5'(DATA_W - 1)) begin
                        st_q <= ST_DONE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Lock latch: locked at power-up, changed only when an instruction completes
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            unlocked_q <= 1'b0;
        end else if (st_q == ST_DONE && op == OP_EXT && sel_fall) begin
            if (ext == EXT_UNLOCK) begin
                unlocked_q <= 1'b1;
            end else if (ext == EXT_LOCK) begin
                unlocked_q <= 1'b0;
            end
        end
    end

    // Arm a job on the select fall; locked device arms nothing
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pend_q <= 2'h0;
            timer_q <= '0;
            fill_idx_q <= '0;
            job_addr_q <= '0;
            job_word_q <= '0;
        end else if (pend_q != 2'h0) begin
            // Internal timer only, no link clock needed
            if (timer_q == 32'(PROG_CYCLES - 1)) begin
                pend_q <= 2'h0;
            end else begin
                timer_q <= timer_q + 32'h1;
            end
            fill_idx_q <= fill_idx_q + 7'h1;
        end else if (sel_fall && st_q == ST_DONE && unlocked_q) begin
            timer_q <= '0;
            fill_idx_q <= '0;
            // Latched now: the receive registers clear as soon as select drops
            job_addr_q <= waddr;
            if (op == OP_WRITE || (op == OP_EXT && ext == EXT_FILL)) begin
                job_word_q <= dat_q;
            end else begin
                job_word_q <= ERASED_WORD;
            end
            if (op == OP_EXT && ext == EXT_ERASE_ALL) begin
                pend_q <= 2'h1;
            end else if (op == OP_EXT && ext == EXT_FILL) begin
                pend_q <= 2'h2;
            end else if (op == OP_WRITE || op == OP_ERASE) begin
                pend_q <= 2'h3;
            end
        end
    end

    // Array store: erase-all and fill visit every word once during the first WORDS cycles; a single word write/erase stores one word
    always_ff @(posedge i_clk) begin
        if ((pend_q == 2'h1 || pend_q == 2'h2) && timer_q < 32'(WORDS)) begin
            mem[fill_idx_q] <= job_word_q; // Overwrites, no erase needed
        end else if (pend_q == 2'h3 && timer_q == 32'h0) begin
            mem[job_addr_q] <= job_word_q;
        end
    end

    assign o_busy = (pend_q != 2'h0);
    assign o_unlocked = unlocked_q;

    // Serial output: read data, or busy/ready status under select
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !sel) begin
            oe_q <= 1'b0;
            so_q <= 1'b1;
            rd_q <= '0;
        end else if (st_q == ST_READ) begin
            // Reads ignore the lock state
            if (!oe_q) begin
                oe_q <= 1'b1;
                so_q <= 1'b0;
                rd_q <= {mem[waddr], 1'b0};
            end else if (lclk_rise) begin
                rd_q <= {rd_q[DATA_W-1:0], 1'b0};
                so_q <= rd_q[DATA_W];
            end
        end else if (sel_rise) begin
            oe_q <= 1'b1;
            so_q <= ~o_busy;
        end else if (oe_q && st_q == ST_IDLE) begin
            so_q <= ~o_busy;
            if (din && lclk_fall && !o_busy) begin
                oe_q <= 1'b0;
            end
        end
    end

    assign link.so_data = so_q;
    assign link.so_oe = oe_q;
endmodule : ee_device

// ### ee_host.sv
// Host end: shifts lock, unlock, erase-all and fill instructions, polls busy
`timescale 1ns/1ns
module ee_host (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [1:0] i_cmd,
    input wire logic [ee_guard_pkg::DATA_W-1:0] i_data,
    ee_link_if.host link,
    output logic o_ready,
    output logic o_done
);
    import ee_guard_pkg::*;

    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_SHIFT = 4'b0010,
        HS_GAP = 4'b0100,
        HS_POLL = 4'b1000
    } host_st_e;

    localparam int FRAME_W = 1 + HDR_W + DATA_W;

    host_st_e st_q;
    logic [FRAME_W-1:0] sh_q;
    logic [5:0] left_q;
    logic [3:0] div_q;
    logic lclk_q;
    logic cs_q;
    logic [7:0] gap_q;
    logic line_m;
    logic line_s;
    logic done_q;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            line_m <= 1'b0;
            line_s <= 1'b0;
        end else begin
            line_m <= link.so_line;
            line_s <= line_m;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_q <= HS_IDLE;
            sh_q <= '0;
            left_q <= '0;
            div_q <= '0;
            lclk_q <= 1'b0;
            cs_q <= 1'b0;
            gap_q <= '0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (st_q)
                HS_IDLE: begin
                    if (i_start) begin
                        // Start bit one, extended opcode, ext code, data
                        sh_q <= {1'b1, OP_EXT, i_cmd, 6'h0, i_data};
                        left_q <= (i_cmd == EXT_FILL) ? 6'(FRAME_W) : 6'(1 + HDR_W);
                        cs_q <= 1'b1;
                        div_q <= '0;
                        st_q <= HS_SHIFT;
                    end
                end
                HS_SHIFT: begin
                    div_q <= div_q + 4'h1;
                    if (div_q == 4'(LCLK_HALF - 1)) begin
                        div_q <= '0;
                        lclk_q <= ~lclk_q;
                        if (lclk_q) begin
                            sh_q <= {sh_q[FRAME_W-2:0], 1'b0};
                            left_q <= left_q - 6'h1;
                            if (left_q == 6'h1) begin
                                cs_q <= 1'b0;
                                gap_q <= '0;
                                st_q <= HS_GAP;
                            end
                        end
                    end
                end
                HS_GAP: begin
                    // Deselect held at least the minimum time
                    gap_q <= gap_q + 8'h1;
                    if (gap_q == 8'(CSMIN_CYC)) begin
                        cs_q <= 1'b1;
                        st_q <= HS_POLL;
                        gap_q <= '0;
                    end
                end
                HS_POLL: begin
                    // Wait out synchroniser delay, then sample status
                    if (gap_q != 8'h8) begin
                        gap_q <= gap_q + 8'h1;
                    end else if (line_s) begin
                        cs_q <= 1'b0;
                        done_q <= 1'b1;
                        st_q <= HS_IDLE;
                    end
                end
                default: st_q <= HS_IDLE;
            endcase
        end
    end

    assign link.select = cs_q;
    assign link.serial_clock_in = lclk_q;
    // Frame is left aligned, so the top bit is always the next one out
    assign link.serial_in = (st_q == HS_SHIFT) ? sh_q[FRAME_W-1] : 1'b0;
    assign o_ready = (st_q == HS_IDLE);
    assign o_done = done_q;
endmodule : ee_host

// ### ee_guard_monitor.sv
// Checker: lock latch, busy cycle and status line behaviour on the link
`timescale 1ns/1ns
module ee_guard_monitor #(
    parameter int PROG_CYCLES = 200
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic select,
    input wire logic serial_clock_in,
    input wire logic so_data,
    input wire logic so_oe,
    input wire logic o_unlocked,
    input wire logic o_busy
);
    int unsigned busy_len_q;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    // Length of the current busy run, zero while idle
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !o_busy) begin
            busy_len_q <= 0;
        end else begin
            busy_len_q <= busy_len_q + 1;
        end
    end

    a_reset_locked: assert property ($rose(i_rst_n) |-> !o_unlocked && !o_busy)
        else $error("lock or busy set after reset");
    a_busy_needs_unlock: assert property ($rose(o_busy) |-> !select && o_unlocked)
        else $error("busy cycle started while locked or selected");
    a_busy_min_len: assert property ($fell(o_busy) |-> busy_len_q >= PROG_CYCLES - 1)
        else $error("busy cycle ended early");
    a_busy_max_len: assert property (busy_len_q <= PROG_CYCLES + 1)
        else $error("busy cycle overran");
    a_poll_shows_busy: assert property ((select && so_oe && o_busy) [*3] |-> !so_data)
        else $error("status high while busy");
    a_poll_shows_ready: assert property ((select && so_oe && !o_busy) [*3] |-> so_data)
        else $error("status low while ready");
    a_lock_change_quiet: assert property ($changed(o_unlocked) |-> !select && !o_busy)
        else $error("lock state changed mid frame or mid cycle");
    a_out_released: assert property (!select [*5] |-> !so_oe)
        else $error("status driven while deselected");
    a_clock_idle: assert property (!select [*3] |-> $stable(serial_clock_in))
        else $error("link clock moved outside a frame");

    c_busy: cover property ($rose(o_busy));
    c_unlock: cover property ($rose(o_unlocked));
    c_lock: cover property ($fell(o_unlocked));
    c_poll_busy: cover property (select && so_oe && o_busy);
endmodule : ee_guard_monitor

// ### test_eeprom_write_guard_bulk_ops.sv
// Testbench: host and device ends joined on one link
`timescale 1ns/1ns
module test_eeprom_write_guard_bulk_ops;
    import ee_guard_pkg::*;
    localparam int PROG = 200;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_start = 1'b0;
    logic [1:0] i_cmd = 2'h0;
    logic [DATA_W-1:0] i_data = 16'h0;
    logic o_unlocked;
    logic o_busy;
    logic o_ready;
    logic o_done;
    int fails = 0;
    int n_compared = 0;
    int busy_seen = 0;
    int nbits = 0;
    logic [26:0] frame_q = 27'h0;
    logic frame_end = 1'b0;

    ee_link_if link ();
    ee_device #(.PROG_CYCLES(PROG)) i_ee_device (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .link(link), .o_unlocked(o_unlocked), .o_busy(o_busy));
    ee_host i_ee_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(i_start), .i_cmd(i_cmd),
        .i_data(i_data), .link(link), .o_ready(o_ready), .o_done(o_done));
    ee_guard_monitor #(.PROG_CYCLES(PROG)) i_monitor (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .select(link.select), .serial_clock_in(link.serial_clock_in), .so_data(link.so_data),
        .so_oe(link.so_oe), .o_unlocked(o_unlocked), .o_busy(o_busy));

    always #20 i_clk = ~i_clk;

    // Only the first frame after a start is the instruction; later frames are polls
    always @(posedge link.serial_clock_in) begin
        if (link.select && !frame_end) begin
            frame_q = {frame_q[25:0], link.serial_in};
            nbits++;
        end
    end
    always @(negedge link.select) frame_end = 1'b1;

    task automatic check_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic check_vec(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check_vec

    // Spot-check first, middle and last word of the array
    task automatic check_array(input logic [15:0] exp);
        check_vec("word first", 32'(exp), 32'(i_ee_device.mem[0]));
        check_vec("word mid", 32'(exp), 32'(i_ee_device.mem[WORDS/2]));
        check_vec("word last", 32'(exp), 32'(i_ee_device.mem[WORDS-1]));
    endtask : check_array

    task automatic run_cmd(input logic [1:0] cmd, input logic [15:0] data, input logic exp_busy);
        int waited;
        logic [26:0] exp_frame;
        exp_frame = {16'h0, 3'h4, cmd, 6'h0};
        if (cmd == EXT_FILL) begin
            exp_frame = {3'h4, cmd, 6'h0, data};
        end
        @(negedge i_clk);
        frame_end = 1'b0;
        nbits = 0;
        frame_q = 27'h0;
        i_cmd = cmd;
        i_data = data;
        i_start = 1'b1;
        @(negedge i_clk);
        i_start = 1'b0;
        busy_seen = 0;
        waited = 0;
        // Bounded by four times the cycle time plus generous room for shifting and polling
        while (o_done !== 1'b1 && waited < 4 * PROG + 2000) begin
            @(posedge i_clk);
            #1;
            if (o_busy === 1'b1) busy_seen++;
            waited++;
        end
        check_bit("done", 1'b1, o_done);
        check_vec("frame bits", (cmd == EXT_FILL) ? 32'd27 : 32'd11, 32'(nbits));
        check_vec("frame", 32'(exp_frame), 32'(frame_q));
        check_bit("busy", exp_busy, busy_seen != 0);
        if (exp_busy) begin
            check_bit("busy span", 1'b1, busy_seen >= PROG - 1 && busy_seen <= PROG + 1);
        end
    endtask : run_cmd

    task automatic test_power_up;
        check_bit("unlocked", 1'b0, o_unlocked);
        check_bit("busy idle", 1'b0, o_busy);
        run_cmd(EXT_ERASE_ALL, 16'h0, 1'b0);
        run_cmd(EXT_FILL, 16'h1234, 1'b0);
        $display("test power_up done");
    endtask : test_power_up

    task automatic test_unlock_erase;
        run_cmd(EXT_UNLOCK, 16'h0, 1'b0);
        check_bit("unlocked", 1'b1, o_unlocked);
        run_cmd(EXT_ERASE_ALL, 16'h0, 1'b1);
        check_array(16'hffff);
        $display("test unlock_erase done");
    endtask : test_unlock_erase

    task automatic test_fill_twice;
        run_cmd(EXT_FILL, 16'ha5c3, 1'b1);
        check_array(16'ha5c3);
        run_cmd(EXT_FILL, 16'h5a3c, 1'b1);
        check_array(16'h5a3c);
        check_bit("unlocked", 1'b1, o_unlocked);
        $display("test fill_twice done");
    endtask : test_fill_twice

    task automatic test_lock_blocks;
        run_cmd(EXT_LOCK, 16'h0, 1'b0);
        check_bit("unlocked", 1'b0, o_unlocked);
        run_cmd(EXT_FILL, 16'hffff, 1'b0);
        run_cmd(EXT_ERASE_ALL, 16'h0, 1'b0);
        check_array(16'h5a3c);
        $display("test lock_blocks done");
    endtask : test_lock_blocks

    task automatic test_reset_relock;
        run_cmd(EXT_UNLOCK, 16'h0, 1'b0);
        @(negedge i_clk);
        i_rst_n = 1'b0;
        repeat (3) @(negedge i_clk);
        i_rst_n = 1'b1;
        check_bit("unlocked after reset", 1'b0, o_unlocked);
        run_cmd(EXT_FILL, 16'h0f0f, 1'b0);
        check_array(16'h5a3c);
        $display("test reset_relock done");
    endtask : test_reset_relock

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (3) @(negedge i_clk);
        i_rst_n = 1'b1;
        test_power_up();
        test_unlock_erase();
        test_fill_twice();
        test_lock_blocks();
        test_reset_relock();
        summarize();
    end

    initial begin
        repeat (40000) @(posedge i_clk);
        fails++;
        summarize();
    end
endmodule : test_eeprom_write_guard_bulk_ops
